// ### rtl/uesc_ep_regs.sv
// Module: one endpoint's status and control flags
`timescale 1ns/1ps
`default_nettype none
module uesc_ep_regs (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Configuration
	input wire logic [1:0] ep_type_i,
	input wire logic ep_dir_in_i,
	input wire logic dbl_bank_i,
	// Software writes (decoded, one-cycle)
	input wire logic [31:0] st_clr_i,
	input wire logic [31:0] st_set_i,
	input wire logic [31:0] ct_clr_i,
	input wire logic [31:0] ct_set_i,
	// Link events for this endpoint
	input wire logic ev_setup_i,
	input wire logic ev_in_i,
	input wire logic ev_out_i,
	input wire logic ev_crc_bad_i,
	// Answer and state
	output uesc_pkg::uesc_ans_t answer_o,
	output logic [31:0] status_o,
	output logic [31:0] control_o,
	output logic irq_o
);
	import uesc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] st;
		logic [31:0] ct;
		logic [1:0] busy;
		logic curr;
		logic toggle;
	} uesc_ep_state_t;
	uesc_ep_state_t cur_ff, nxt_cur;
	logic is_ctrl, is_iso, nbanks_full;

	assign is_ctrl = (ep_type_i == EPT_CONTROL);
	assign is_iso = (ep_type_i == EPT_ISO);
	assign nbanks_full = dbl_bank_i ? (cur_ff.busy == 2'h2) : (cur_ff.busy == 2'h1);

	// Answer to the current token, combinational from state
	always_comb begin
		answer_o = UESC_ANS_NONE;
		if (ev_setup_i) begin
			answer_o = UESC_ANS_ACK;
		end else if (ev_in_i || ev_out_i) begin
			if (cur_ff.ct[CT_SILENT]) begin
				answer_o = UESC_ANS_NONE;
			end else if (cur_ff.ct[CT_STALL_REQ]) begin
				answer_o = UESC_ANS_STALL;
			end else if (cur_ff.ct[CT_BANK0_HOLD + 32'(cur_ff.curr)]) begin
				answer_o = UESC_ANS_NAK;
			end else if (ev_in_i) begin
				answer_o = (cur_ff.busy == 2'h0) ? UESC_ANS_NAK
					: (cur_ff.toggle ? UESC_ANS_DATA1 : UESC_ANS_DATA0);
			end else begin
				answer_o = nbanks_full ? UESC_ANS_NAK : UESC_ANS_ACK;
			end
		end
	end

	// Next-state logic
	always_comb begin
		logic sent, got, kill_done;
		sent = (answer_o == UESC_ANS_DATA0) || (answer_o == UESC_ANS_DATA1);
		got = ev_out_i && (answer_o == UESC_ANS_ACK);
		kill_done = 1'b0;
		nxt_cur = cur_ff;
		// Software clears first so hardware sets below win
		nxt_cur.st = (cur_ff.st & ~(st_clr_i & UESC_STATUS_SW_MASK))
			| (st_set_i & UESC_STATUS_SW_MASK);
		nxt_cur.ct = (cur_ff.ct & ~(ct_clr_i & UESC_CONTROL_SW_MASK))
			| (ct_set_i & UESC_CONTROL_SW_MASK);
		nxt_cur.ct[CT_TOGGLE_RESET] = 1'b0;
		nxt_cur.ct[CT_DISCARD] = cur_ff.ct[CT_DISCARD] | ct_set_i[CT_DISCARD];
		if (ct_set_i[CT_TOGGLE_RESET]) begin
			nxt_cur.toggle = 1'b0;
		end
		if (ev_setup_i) begin
			nxt_cur.ct[CT_STALL_REQ] = 1'b0;
			nxt_cur.ct[CT_SILENT] = 1'b0;
			nxt_cur.toggle = 1'b1;
			if (is_ctrl) nxt_cur.st[ST_SETUP_ERRF] = 1'b1;
		end
		if (answer_o == UESC_ANS_STALL) nxt_cur.st[ST_STALL_CRC] = 1'b1;
		if (answer_o == UESC_ANS_NAK && ev_in_i) nxt_cur.st[ST_NAK_IN] = 1'b1;
		if (answer_o == UESC_ANS_NAK && ev_out_i) nxt_cur.st[ST_NAK_OUT] = 1'b1;
		if (is_ctrl) begin
			// Control: flags drive bank handoff, no handoff bit
			// A free control bank offers itself for the next IN packet
			if (cur_ff.busy == 2'h0 && !cur_ff.st[ST_IN_READY]) nxt_cur.st[ST_IN_READY] = 1'b1;
			if (st_clr_i[ST_OUT_RECEIVED] && cur_ff.st[ST_OUT_RECEIVED]) nxt_cur.busy = 2'h0;
			if (st_clr_i[ST_IN_READY] && cur_ff.st[ST_IN_READY]) nxt_cur.busy = 2'h1;
			if (got) begin
				nxt_cur.busy = 2'h1;
				nxt_cur.st[ST_OUT_RECEIVED] = 1'b1;
				nxt_cur.toggle = ~cur_ff.toggle;
			end
			if (sent) begin
				nxt_cur.busy = 2'h0;
				nxt_cur.st[ST_IN_READY] = 1'b1;
				nxt_cur.toggle = ~cur_ff.toggle;
			end
			nxt_cur.ct[CT_HANDOFF] = 1'b0;
		end else begin
			nxt_cur.st[ST_OUT_RECEIVED] = nxt_cur.st[ST_OUT_RECEIVED] & ~ep_dir_in_i;
			nxt_cur.st[ST_IN_READY] = nxt_cur.st[ST_IN_READY] & ep_dir_in_i;
			if (ev_crc_bad_i && is_iso && ev_out_i) nxt_cur.st[ST_STALL_CRC] = 1'b1;
			if (ct_clr_i[CT_HANDOFF] && cur_ff.ct[CT_HANDOFF]) begin
				if (ep_dir_in_i) nxt_cur.busy = cur_ff.busy + 2'h1;
				else nxt_cur.busy = cur_ff.busy - 2'h1;
				nxt_cur.curr = dbl_bank_i ? ~cur_ff.curr : 1'b0;
			end
			if (ep_dir_in_i && cur_ff.ct[CT_DISCARD] && cur_ff.busy != 2'h0) begin
				// Two ready banks: first is sent, last written is killed
				kill_done = !sent || cur_ff.busy == 2'h2;
				nxt_cur.busy = nxt_cur.busy - 2'h1;
				if (sent && cur_ff.busy == 2'h2) nxt_cur.busy = nxt_cur.busy - 2'h1;
				nxt_cur.ct[CT_DISCARD] = 1'b0;
				nxt_cur.st[ST_IN_READY] = 1'b1;
				nxt_cur.ct[CT_HANDOFF] = 1'b1;
			end else if (ep_dir_in_i && cur_ff.ct[CT_DISCARD]) begin
				nxt_cur.ct[CT_DISCARD] = 1'b0;
			end else if (sent) begin
				nxt_cur.busy = nxt_cur.busy - 2'h1;
				nxt_cur.toggle = ~cur_ff.toggle;
				nxt_cur.st[ST_IN_READY] = 1'b1;
				nxt_cur.ct[CT_HANDOFF] = 1'b1;
			end
			if (got) begin
				nxt_cur.busy = nxt_cur.busy + 2'h1;
				nxt_cur.toggle = ~cur_ff.toggle;
				nxt_cur.st[ST_OUT_RECEIVED] = 1'b1;
				nxt_cur.ct[CT_HANDOFF] = 1'b1;
			end
			if (kill_done && nxt_cur.busy == 2'h0) nxt_cur.st[ST_IN_READY] = 1'b1;
			// An IN endpoint whose current bank is free hands it to software
			if (ep_dir_in_i && !cur_ff.ct[CT_HANDOFF] && !nbanks_full) begin
				nxt_cur.st[ST_IN_READY] = 1'b1;
				nxt_cur.ct[CT_HANDOFF] = 1'b1;
			end
		end
		if (ct_set_i[CT_TOGGLE_RESET]) nxt_cur.toggle = 1'b0;
	end

	// Register the state
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Visible status and control words
	always_comb begin
		status_o = cur_ff.st;
		status_o[ST_BUSY_LO + 1 -: 2] = cur_ff.busy;
		status_o[ST_DTSEQ] = cur_ff.toggle;
		status_o[ST_CURRBK] = is_ctrl ? 1'b0 : cur_ff.curr;
		control_o = cur_ff.ct;
		irq_o = |(cur_ff.st[6:0] & cur_ff.ct[6:0])
			| (cur_ff.st[ST_RAM_ERR] & cur_ff.ct[CT_RAM_ERR_EN]);
	end
endmodule // uesc_ep_regs
`default_nettype wire

// ### rtl/uesc_pkg.sv
// Package: register map, field positions and types for endpoint status and control
package uesc_pkg;
	// Register offsets (endpoint n adds n*4)
	localparam logic [11:0] UESC_STATUS_OFS = 12'h130;
	localparam logic [11:0] UESC_STATUS_CLEAR_OFS = 12'h160;
	localparam logic [11:0] UESC_STATUS_SET_OFS = 12'h190;
	localparam logic [11:0] UESC_CONTROL_OFS = 12'h1C0;
	localparam logic [11:0] UESC_CONTROL_SET_OFS = 12'h1F0;
	localparam logic [11:0] UESC_CONTROL_CLEAR_OFS = 12'h220;
	localparam logic [11:0] UESC_CONFIG_OFS = 12'h100;
	localparam logic [11:0] UESC_WINDOW_SPAN = 12'h020;
	localparam logic [11:0] UESC_CMD_OFS = 12'h000;
	localparam logic [11:0] UESC_ANSWER_OFS = 12'h004;
	localparam int UESC_NUM_EP = 8;
	// Status bit positions
	localparam int ST_IN_READY = 0;
	localparam int ST_OUT_RECEIVED = 1;
	localparam int ST_SETUP_ERRF = 2;
	localparam int ST_NAK_OUT = 3;
	localparam int ST_NAK_IN = 4;
	localparam int ST_STALL_CRC = 6;
	localparam int ST_RAM_ERR = 11;
	localparam int ST_BUSY_LO = 12;
	localparam int ST_CURRBK = 14;
	localparam int ST_DTSEQ = 8;
	// Control bit positions
	localparam int CT_IN_READY_EN = 0;
	localparam int CT_OUT_RECEIVED_EN = 1;
	localparam int CT_SETUP_EN = 2;
	localparam int CT_NAK_OUT_EN = 3;
	localparam int CT_NAK_IN_EN = 4;
	localparam int CT_STALL_EN = 6;
	localparam int CT_SILENT = 8;
	localparam int CT_RAM_ERR_EN = 11;
	localparam int CT_BUSY_EN = 12;
	localparam int CT_DISCARD = 13;
	localparam int CT_HANDOFF = 14;
	localparam int CT_TOGGLE_RESET = 18;
	localparam int CT_STALL_REQ = 19;
	localparam int CT_BANK0_HOLD = 24;
	localparam int CT_BANK1_HOLD = 25;
	localparam logic [31:0] UESC_STATUS_SW_MASK = 32'h0000_085F;
	localparam logic [31:0] UESC_CONTROL_SW_MASK = 32'h030C_795F;
	localparam logic [31:0] UESC_RESET_VALUE = 32'h0000_0000;
	// Endpoint types
	localparam logic [1:0] EPT_CONTROL = 2'h0;
	localparam logic [1:0] EPT_ISO = 2'h1;
	// Token kinds seen on the link
	typedef enum logic [1:0] {UESC_TOK_SETUP, UESC_TOK_IN, UESC_TOK_OUT, UESC_TOK_NONE} uesc_tok_t;
	// Device answers
	typedef enum logic [2:0] {UESC_ANS_NONE, UESC_ANS_ACK, UESC_ANS_NAK, UESC_ANS_STALL,
		UESC_ANS_DATA0, UESC_ANS_DATA1} uesc_ans_t;
endpackage

// ### rtl/uesc_link_if.sv
// Interface: token link between host end and endpoint end
`timescale 1ns/1ps
`default_nettype none
interface uesc_link_if;
	import uesc_pkg::*;
	logic tok_valid; // One-cycle token strobe
	uesc_tok_t tok_kind;
	logic [2:0] tok_ep;
	logic tok_crc_bad; // OUT data arrived with bad CRC
	logic ans_valid; // One-cycle answer strobe
	uesc_ans_t ans_kind;
	modport host_mp (output tok_valid, output tok_kind, output tok_ep, output tok_crc_bad,
		input ans_valid, input ans_kind);
	modport dev_mp (input tok_valid, input tok_kind, input tok_ep, input tok_crc_bad,
		output ans_valid, output ans_kind);
endinterface
`default_nettype wire

// ### rtl/uesc_device.sv
// Module: device end, eight endpoints with register port
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Control OUT flag clear releases bank
// - Software clears OUT flag before handoff
// - Control OUT packet sets flag, interrupt
// - Data OUT full bank sets flag, handoff
// - Control IN flag clear sends packet
// - Software clears IN flag before handoff
// - Control free bank sets IN flag
// - Data IN free bank sets flag, handoff
// - Status clear writes clear ones only
// - Status set writes set ones only
// - Held bank answers NAK except SETUP
// - Stall request; cleared by SETUP or clear
// - Toggle reset forces DATA0, reads zero
// - Control endpoints: handoff reads zero
// - IN handoff clear commits, next bank
// - OUT handoff clear frees, next bank
// - Discard bit self-clears when done
// - Discard completion decrements count
// - Two ready: send first, kill last
// - Silent mode ignores all but SETUP
// - Enables via set and clear registers
// - Busy count tracks filled banks
module uesc_device (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Register port
	input wire logic [11:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Endpoint interrupts
	output logic [7:0] ep_irq_o,
	// Link
	uesc_link_if.dev_mp link
);
	import uesc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0][31:0] cfg;
		logic [31:0] rdata;
		logic [7:0] irq;
		logic ans_valid;
		uesc_ans_t ans_kind;
	} uesc_dev_state_t;
	uesc_dev_state_t cur_ff, nxt_cur;
	logic [7:0][31:0] st_clr, st_set, ct_clr, ct_set, status, control;
	uesc_ans_t [7:0] answer;
	logic [7:0] irq;

	// Address falls on a word inside a register block
	function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
		return (a >= base) && (a < base + UESC_WINDOW_SPAN) && (a[1:0] == 2'h0);
	endfunction

	// Endpoint slot counted from the block start; several blocks do not start on a 32-byte line
	function automatic logic [2:0] slot(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] ofs;
		ofs = a - base;
		return ofs[4:2];
	endfunction

	// Address names endpoint n inside the block at base
	function automatic logic hit_ep(input logic [11:0] a, input logic [11:0] base,
		input logic [2:0] n);
		return hit(a, base) && (slot(a, base) == n);
	endfunction

	// One register block per endpoint
	for (genvar n = 0; n < UESC_NUM_EP; n++) begin : g_ep
		logic tok;
		assign tok = link.tok_valid && (link.tok_ep == 3'(n));
		assign st_clr[n] = (reg_wr_i && hit_ep(reg_addr_i, UESC_STATUS_CLEAR_OFS, 3'(n)))
			? reg_wdata_i : '0;
		assign st_set[n] = (reg_wr_i && hit_ep(reg_addr_i, UESC_STATUS_SET_OFS, 3'(n)))
			? reg_wdata_i : '0;
		assign ct_clr[n] = (reg_wr_i && hit_ep(reg_addr_i, UESC_CONTROL_CLEAR_OFS, 3'(n)))
			? reg_wdata_i : '0;
		assign ct_set[n] = (reg_wr_i && hit_ep(reg_addr_i, UESC_CONTROL_SET_OFS, 3'(n)))
			? reg_wdata_i : '0;
		uesc_ep_regs u_ep (
			.clk_sys_i(clk_sys_i),
			.rst_i(rst_i),
			.ep_type_i(cur_ff.cfg[n][12:11]),
			.ep_dir_in_i(cur_ff.cfg[n][8] && (cur_ff.cfg[n][12:11] != EPT_CONTROL)),
			.dbl_bank_i(cur_ff.cfg[n][2] && (cur_ff.cfg[n][12:11] != EPT_CONTROL)),
			.st_clr_i(st_clr[n]),
			.st_set_i(st_set[n]),
			.ct_clr_i(ct_clr[n]),
			.ct_set_i(ct_set[n]),
			.ev_setup_i(tok && link.tok_kind == UESC_TOK_SETUP),
			.ev_in_i(tok && link.tok_kind == UESC_TOK_IN),
			.ev_out_i(tok && link.tok_kind == UESC_TOK_OUT),
			.ev_crc_bad_i(link.tok_crc_bad),
			.answer_o(answer[n]),
			.status_o(status[n]),
			.control_o(control[n]),
			.irq_o(irq[n])
		);
	end

	// Register reads, configuration writes and link answer
	always_comb begin
		logic [2:0] idx_cfg, idx_st, idx_ct;
		idx_cfg = slot(reg_addr_i, UESC_CONFIG_OFS);
		idx_st = slot(reg_addr_i, UESC_STATUS_OFS);
		idx_ct = slot(reg_addr_i, UESC_CONTROL_OFS);
		nxt_cur = cur_ff;
		nxt_cur.rdata = '0;
		nxt_cur.irq = irq;
		nxt_cur.ans_valid = link.tok_valid && (answer[link.tok_ep] != UESC_ANS_NONE);
		nxt_cur.ans_kind = answer[link.tok_ep];
		if (reg_wr_i && hit(reg_addr_i, UESC_CONFIG_OFS)) begin
			nxt_cur.cfg[idx_cfg] = reg_wdata_i & 32'h0000_1904;
		end
		if (reg_rd_i) begin
			if (hit(reg_addr_i, UESC_CONFIG_OFS)) nxt_cur.rdata = cur_ff.cfg[idx_cfg];
			else if (hit(reg_addr_i, UESC_STATUS_OFS)) nxt_cur.rdata = status[idx_st];
			else if (hit(reg_addr_i, UESC_CONTROL_OFS)) nxt_cur.rdata = control[idx_ct];
		end
	end

	// Register the state
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign reg_rdata_o = cur_ff.rdata;
	assign ep_irq_o = cur_ff.irq;
	assign link.ans_valid = cur_ff.ans_valid;
	assign link.ans_kind = cur_ff.ans_kind;
endmodule // uesc_device
`default_nettype wire

// ### rtl/uesc_host.sv
// Module: host end, issues tokens on command and captures answers
`timescale 1ns/1ps
`default_nettype none
module uesc_host (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Command port
	input wire logic [11:0] cmd_addr_i,
	input wire logic [31:0] cmd_wdata_i,
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	output logic [31:0] cmd_rdata_o,
	// Link
	uesc_link_if.host_mp link
);
	import uesc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic tok_valid;
		uesc_tok_t tok_kind;
		logic [2:0] tok_ep;
		logic crc_bad;
		logic ans_seen;
		uesc_ans_t ans_kind;
		logic [31:0] rdata;
	} uesc_host_state_t;
	uesc_host_state_t cur_ff, nxt_cur;

	// Command write launches one token; answer word is read back
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.tok_valid = 1'b0;
		nxt_cur.rdata = '0;
		if (cmd_wr_i && cmd_addr_i == UESC_CMD_OFS) begin
			nxt_cur.tok_valid = 1'b1;
			nxt_cur.tok_ep = cmd_wdata_i[2:0];
			nxt_cur.tok_kind = uesc_tok_t'(cmd_wdata_i[5:4]);
			nxt_cur.crc_bad = cmd_wdata_i[8];
			nxt_cur.ans_seen = 1'b0;
			nxt_cur.ans_kind = UESC_ANS_NONE;
		end
		if (link.ans_valid) begin
			nxt_cur.ans_seen = 1'b1;
			nxt_cur.ans_kind = link.ans_kind;
		end
		if (cmd_rd_i && cmd_addr_i == UESC_ANSWER_OFS) begin
			nxt_cur.rdata = {27'h0, cur_ff.ans_seen, 1'b0, cur_ff.ans_kind};
		end
	end

	// Register the state
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign cmd_rdata_o = cur_ff.rdata;
	assign link.tok_valid = cur_ff.tok_valid;
	assign link.tok_kind = cur_ff.tok_kind;
	assign link.tok_ep = cur_ff.tok_ep;
	assign link.tok_crc_bad = cur_ff.crc_bad;
endmodule // uesc_host
`default_nettype wire

// ### sim/uesc_link_props.sv
// Checker: token and answer timing on the link between host and device
`timescale 1ns/1ps
`default_nettype none
module uesc_link_props (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Link signals
	input wire logic tok_valid,
	input var uesc_pkg::uesc_tok_t tok_kind,
	input wire logic [2:0] tok_ep,
	input wire logic tok_crc_bad,
	input wire logic ans_valid,
	input var uesc_pkg::uesc_ans_t ans_kind
);
	import uesc_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Token phases that lead to an answer one cycle later
	sequence s_setup;
		tok_valid && tok_kind == UESC_TOK_SETUP;
	endsequence
	sequence s_in;
		tok_valid && tok_kind == UESC_TOK_IN;
	endsequence
	sequence s_out;
		tok_valid && tok_kind == UESC_TOK_OUT;
	endsequence
	property p_ans_follows;
		ans_valid |-> $past(tok_valid);
	endproperty
	a_ans_follows: assert property (p_ans_follows) else $error("answer without token");
	property p_setup_ack;
		s_setup |=> ans_valid && ans_kind == UESC_ANS_ACK;
	endproperty
	a_setup_ack: assert property (p_setup_ack) else $error("setup not acked");
	property p_in_kind;
		s_in |=> !ans_valid || ans_kind inside {UESC_ANS_NAK, UESC_ANS_STALL,
			UESC_ANS_DATA0, UESC_ANS_DATA1};
	endproperty
	a_in_kind: assert property (p_in_kind) else $error("bad answer to in");
	property p_out_kind;
		s_out |=> !ans_valid || ans_kind inside {UESC_ANS_ACK, UESC_ANS_NAK, UESC_ANS_STALL};
	endproperty
	a_out_kind: assert property (p_out_kind) else $error("bad answer to out");
	property p_ans_pulse;
		ans_valid |=> !ans_valid;
	endproperty
	a_ans_pulse: assert property (p_ans_pulse) else $error("answer too long");
	property p_ans_named;
		ans_valid |-> ans_kind != UESC_ANS_NONE;
	endproperty
	a_ans_named: assert property (p_ans_named) else $error("empty answer");
	property p_tok_pulse;
		$rose(tok_valid) |=> !tok_valid [*2];
	endproperty
	a_tok_pulse: assert property (p_tok_pulse) else $error("token too long");
	property p_tok_named;
		tok_valid |-> tok_kind != UESC_TOK_NONE && !tok_crc_bad && tok_ep <= 3'h7;
	endproperty
	a_tok_named: assert property (p_tok_named) else $error("bad token");
endmodule // uesc_link_props
`default_nettype wire

// ### sim/uesc_bench.sv
// Bench: host end and device end joined by the link, driven on their ports
`timescale 1ns/1ps
`default_nettype none
module uesc_bench;
	import uesc_pkg::*;
	localparam logic [11:0] ST = UESC_STATUS_OFS;
	localparam logic [11:0] SC = UESC_STATUS_CLEAR_OFS;
	localparam logic [11:0] SS = UESC_STATUS_SET_OFS;
	localparam logic [11:0] CO = UESC_CONTROL_OFS;
	localparam logic [11:0] CS = UESC_CONTROL_SET_OFS;
	localparam logic [11:0] CC = UESC_CONTROL_CLEAR_OFS;
	localparam logic [11:0] CF = UESC_CONFIG_OFS;
	logic clk_sys_i = 1'h0;
	logic rst_i = 1'h1;
	logic [11:0] ra = 12'h000;
	logic [11:0] ca = 12'h000;
	logic [31:0] rwd = 32'h0;
	logic [31:0] cwd = 32'h0;
	logic rwr = 1'h0;
	logic rrs = 1'h0;
	logic cwr = 1'h0;
	logic crs = 1'h0;
	logic [31:0] rrd;
	logic [31:0] crd;
	logic [7:0] irq;
	int failures = 0;
	int check_count = 0;
	int ans_cnt = 0;
	uesc_ans_t tgl [3] = '{UESC_ANS_DATA0, UESC_ANS_DATA0, UESC_ANS_DATA1};
	uesc_link_if uesc_link_if_i ();
	uesc_device uesc_device_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(ra),
		.reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrs), .reg_rdata_o(rrd),
		.ep_irq_o(irq), .link(uesc_link_if_i.dev_mp));
	uesc_host uesc_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_addr_i(ca),
		.cmd_wdata_i(cwd), .cmd_wr_i(cwr), .cmd_rd_i(crs), .cmd_rdata_o(crd),
		.link(uesc_link_if_i.host_mp));
	uesc_link_props uesc_link_props_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.tok_valid(uesc_link_if_i.tok_valid), .tok_kind(uesc_link_if_i.tok_kind),
		.tok_ep(uesc_link_if_i.tok_ep), .tok_crc_bad(uesc_link_if_i.tok_crc_bad),
		.ans_valid(uesc_link_if_i.ans_valid), .ans_kind(uesc_link_if_i.ans_kind));
	// Clock and answer counter
	initial forever #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (uesc_link_if_i.ans_valid === 1'h1) ans_cnt <= ans_cnt + 1;
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		check_count++;
		if (got !== e) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, e);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		ra <= a;
		rwd <= d;
		rwr <= 1'h1;
		@(posedge clk_sys_i);
		rwr <= 1'h0;
	endtask
	// Read from device registers or host answer port, masked compare
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
		input bit h = 1'h0);
		@(posedge clk_sys_i);
		ra <= a;
		ca <= a;
		rrs <= !h;
		crs <= h;
		@(posedge clk_sys_i);
		rrs <= 1'h0;
		crs <= 1'h0;
		#1 chk((h ? crd : rrd) & m, e);
	endtask
	// Token through the host end; NONE means no answer is expected
	task automatic tok(input uesc_tok_t k, input logic [2:0] ep, input uesc_ans_t e);
		int n;
		n = ans_cnt;
		@(posedge clk_sys_i);
		ca <= UESC_CMD_OFS;
		cwd <= {26'h0, k, 1'h0, ep};
		cwr <= 1'h1;
		@(posedge clk_sys_i);
		cwr <= 1'h0;
		repeat (3) @(posedge clk_sys_i);
		#1 chk(32'(ans_cnt - n), (e == UESC_ANS_NONE) ? 32'h0 : 32'h1);
		if (e != UESC_ANS_NONE) rd(UESC_ANSWER_OFS, 32'h17, {27'h0, 1'h1, 1'h0, e}, 1'h1);
	endtask
	// Interrupt line of one endpoint after it settles
	task automatic irq_is(input int n, input logic v);
		repeat (2) @(posedge clk_sys_i);
		#1 chk({31'h0, irq[n]}, {31'h0, v});
	endtask
	task automatic tend(input int t);
		$display("test %0d done, checks %0d", t, check_count);
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#200000;
		failures++;
		final_report();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		rd(CO, 32'hFFFFFFFF, 32'h0);
		rd(12'hFFC, 32'hFFFFFFFF, 32'h0);
		wr(CS, 32'h0004185F);
		rd(CO, 32'hFFFFFFFF, 32'h0000185F);
		wr(CC, 32'h0000185F);
		rd(CO, 32'hFFFFFFFF, 32'h0);
		tend(1);
		// Status set, clear and interrupt on endpoint 1
		wr(SS + 12'h4, 32'h00000858);
		wr(SS + 12'h4, 32'h0);
		rd(ST + 12'h4, 32'h00000858, 32'h00000858);
		wr(CS + 12'h4, 32'h00000010);
		irq_is(1, 1'h1);
		wr(SC + 12'h4, 32'h00000058);
		wr(SC + 12'h4, 32'h0);
		rd(ST + 12'h4, 32'h00000858, 32'h00000800);
		irq_is(1, 1'h0);
		// Stall request on endpoint 1
		wr(CS + 12'h4, 32'h00080000);
		tok(UESC_TOK_IN, 3'h1, UESC_ANS_STALL);
		rd(ST + 12'h4, 32'h00000040, 32'h00000040);
		wr(CC + 12'h4, 32'h00080000);
		tok(UESC_TOK_IN, 3'h1, UESC_ANS_NAK);
		// Control OUT on endpoint 1: flag, interrupt, bank release
		wr(SC + 12'h4, 32'h00000010);
		wr(CS + 12'h4, 32'h00000002);
		tok(UESC_TOK_OUT, 3'h1, UESC_ANS_ACK);
		rd(ST + 12'h4, 32'h00003002, 32'h00001002);
		irq_is(1, 1'h1);
		wr(SC + 12'h4, 32'h00000002);
		rd(ST + 12'h4, 32'h00003002, 32'h0);
		irq_is(1, 1'h0);
		rd(CO + 12'h4, 32'h00004000, 32'h0);
		tend(2);
		// Bulk OUT endpoint 2: held bank, then a full bank handed over
		wr(CF + 12'h8, 32'h00001000);
		wr(CS + 12'h8, 32'h01000000);
		tok(UESC_TOK_OUT, 3'h2, UESC_ANS_NAK);
		tok(UESC_TOK_SETUP, 3'h2, UESC_ANS_ACK);
		wr(CC + 12'h8, 32'h01000000);
		tok(UESC_TOK_OUT, 3'h2, UESC_ANS_ACK);
		rd(ST + 12'h8, 32'h00003003, 32'h00001002);
		rd(CO + 12'h8, 32'h00004000, 32'h00004000);
		wr(SC + 12'h8, 32'h00000002);
		wr(CC + 12'h8, 32'h00004000);
		rd(ST + 12'h8, 32'h00003002, 32'h0);
		rd(CO + 12'h8, 32'h00004000, 32'h0);
		// Silent endpoint 3 ignores IN, SETUP ends it
		wr(CS + 12'hC, 32'h00000100);
		tok(UESC_TOK_IN, 3'h3, UESC_ANS_NONE);
		tok(UESC_TOK_SETUP, 3'h3, UESC_ANS_ACK);
		rd(CO + 12'hC, 32'h00000100, 32'h0);
		tend(3);
		// Bulk IN endpoint 4: commits, toggle sequence and its reset
		wr(CF + 12'h10, 32'h00001100);
		foreach (tgl[i]) begin
			if (i == 1) wr(CS + 12'h10, 32'h00040000);
			wr(SC + 12'h10, 32'h00000001);
			wr(CC + 12'h10, 32'h00004000);
			rd(ST + 12'h10, 32'h00003000, 32'h00001000);
			tok(UESC_TOK_IN, 3'h4, tgl[i]);
			rd(ST + 12'h10, 32'h00003001, 32'h00000001);
		end
		// Discard of a committed bank on endpoint 4
		wr(SC + 12'h10, 32'h00000001);
		wr(CC + 12'h10, 32'h00004000);
		wr(CS + 12'h10, 32'h00002000);
		rd(CO + 12'h10, 32'h00006000, 32'h00004000);
		rd(ST + 12'h10, 32'h00003001, 32'h00000001);
		// Control IN on endpoint 0
		wr(SC, 32'h00000001);
		rd(ST, 32'h00003001, 32'h00001000);
		tok(UESC_TOK_IN, 3'h0, UESC_ANS_DATA0);
		rd(ST, 32'h00003001, 32'h00000001);
		tend(4);
		final_report();
	end
endmodule // uesc_bench
`default_nettype wire
